// *** logic/pic_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// - A source event sets its pending flag regardless of any enable.
// - An enabled request is called at the next instruction boundary.
// - Routines end with return; the CPU resumes the interrupted flow.
// - Global enable low blocks every request whatever the source enables.
// - Each source has its own enable; masking leaves pending untouched.
// - Some flags clear on vectoring; software clears the rest.
// - A flag still set after return requests again at once.
// - Software setting a pending flag acts like a hardware event.
// - Each source has a two-bit priority, four levels.
// - Only strictly higher levels preempt; level 3 is never preempted.
// - Level is high-register bit over low-register bit; 11 is highest.
// - All sources reset to the lowest level.
// - Highest level wins; equal levels go to lower vector position.
// - Requests are resolved each cycle; detection takes one cycle.
// - After a return one more instruction runs before the call.
// - Worst response is 18 cycles including return and a divide.
// - Equal or lower requests wait for the return and one instruction.
// - On leaving a routine the best pending request goes next.
// - Reset vector 0, sources at 3 plus 8 per position; 19, 20 unused.
module pic_ctrl
  import pic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_SRC-1:0] src_event_i,
  input wire logic instr_done_i,
  input wire logic reti_i,
  output logic irq_req_o,
  output logic [VEC_W-1:0] irq_vec_o,
  output logic irq_take_o
);

  ////////////////////////////////////////////////////////////////////////
  logic [PRI_W-1:0] primary;
  logic [EXT_W-1:0] ext_mask;
  logic [NUM_SRC-1:0] prio_lo;
  logic [NUM_SRC-1:0] prio_hi;
  logic [NUM_SRC-1:0] aux_en;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] req_vec;
  logic [NUM_SRC-1:0] gate_q;
  logic [NUM_SRC-1:0] evt_v;
  logic [NUM_SRC-1:0] sw_set;
  logic [NUM_SRC-1:0] sw_clr;
  logic [NUM_SRC-1:0] hw_clr;
  logic [NUM_SRC-1:0] src_hot;
  logic [LVL_W-1:0] lvl [NUM_SRC];
  logic [NUM_LVL-1:0] in_srv;
  logic [LVL_W-1:0] top;
  logic busy;
  logic global_en;
  pic_win_t win;
  logic next_req;
  logic [VEC_W-1:0] next_vec;
  logic [SRC_W-1:0] src_q;
  logic [LVL_W-1:0] lvl_q;
  logic [DAT_W-1:0] wmask;
  logic [DAT_W-1:0] rd_data;
  logic bus_req;
  logic wr;
  pic_status_t status;

  function automatic logic [DAT_W-1:0] merge(
    input logic [DAT_W-1:0] old_v,
    input logic [DAT_W-1:0] new_v,
    input logic [DAT_W-1:0] m
  );
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack drops the cycle after it rises
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr = bus_req & wb_we_i & wb_ack_o;
  assign wmask = {{BYTE_W{wb_sel_i[3]}}, {BYTE_W{wb_sel_i[2]}},
                  {BYTE_W{wb_sel_i[1]}}, {BYTE_W{wb_sel_i[0]}}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req & ~wb_ack_o;
  end

  assign status = '{src: src_q, req: irq_req_o, in_srv: in_srv};

  always_comb
  begin
    rd_data = '0;
    unique case (wb_adr_i)
      OFS_PRIMARY: rd_data = DAT_W'(primary);
      OFS_EXT_MASK: rd_data = DAT_W'(ext_mask);
      OFS_PRIO_LO: rd_data = DAT_W'(prio_lo);
      OFS_PRIO_HI: rd_data = DAT_W'(prio_hi);
      OFS_AUX_EN: rd_data = DAT_W'(aux_en);
      OFS_PEND: rd_data = DAT_W'(pend);
      OFS_STATUS: rd_data = DAT_W'(status);
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (bus_req & ~wb_ack_o)
      wb_dat_o <= rd_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable and priority registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      primary <= PRIMARY_RST;
    else if (wr && wb_adr_i == OFS_PRIMARY)
      primary <= PRI_W'(merge(DAT_W'(primary), wb_dat_i, wmask));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ext_mask <= EXT_RST;
    else if (wr && wb_adr_i == OFS_EXT_MASK)
      ext_mask <= EXT_W'(merge(DAT_W'(ext_mask), wb_dat_i, wmask));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prio_lo <= PRIO_RST;
    else if (wr && wb_adr_i == OFS_PRIO_LO)
      prio_lo <= NUM_SRC'(merge(DAT_W'(prio_lo), wb_dat_i, wmask));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prio_hi <= PRIO_RST;
    else if (wr && wb_adr_i == OFS_PRIO_HI)
      prio_hi <= NUM_SRC'(merge(DAT_W'(prio_hi), wb_dat_i, wmask));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      aux_en <= AUX_RST;
    else if (wr && wb_adr_i == OFS_AUX_EN)
      aux_en <= NUM_SRC'(merge(DAT_W'(aux_en), wb_dat_i, wmask));
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending flags: set wins over any clear in the same cycle
  assign evt_v = src_event_i & SRC_VALID;
  assign sw_set = (wr && wb_adr_i == OFS_PEND) ?
                  NUM_SRC'(wb_dat_i & wmask) & SRC_VALID : '0;
  assign sw_clr = (wr && wb_adr_i == OFS_PEND_CLR) ?
                  NUM_SRC'(wb_dat_i & wmask) : '0;
  assign src_hot = {{(NUM_SRC-1){1'b0}}, 1'b1} << src_q;
  assign hw_clr = irq_take_o ? (src_hot & HW_CLR) : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend <= '0;
    else
      pend <= (pend & ~(sw_clr | hw_clr)) | evt_v | sw_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-source gating and level
  assign global_en = primary[GLB_BIT];
  assign en_vec = {ext_mask, primary[PRI_W-2:0]};

  for (genvar g = 0; g < NUM_SRC; g++)
  begin : g_src
    assign lvl[g] = {prio_hi[g], prio_lo[g]};
    // Global enable gates all; own enable gates each, auxiliary enable only sources with one
    assign req_vec[g] = global_en & en_vec[g] & pend[g] & SRC_VALID[g]
                        & (aux_en[g] | ~HAS_AUX[g]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbitration: scanning downward with >= lets the lower position win
  always_comb
  begin
    win = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req_vec[i] && (!win.valid || lvl[i] >= win.lvl))
      begin
        win.valid = 1'b1;
        win.lvl = lvl[i];
        win.src = i[SRC_W-1:0];
      end
    end
  end

  // Highest level currently in service sets the preemption threshold
  always_comb
  begin
    top = '0;
    for (int l = 0; l < NUM_LVL; l++)
    begin
      if (in_srv[l])
        top = l[LVL_W-1:0];
    end
  end

  assign busy = |in_srv;
  // Strictly higher only, so level 3 can never be preempted
  assign next_req = win.valid && (!busy || win.lvl > top);
  assign next_vec = VEC_BASE + VEC_W'(win.src) * VEC_STEP;

  ////////////////////////////////////////////////////////////////////////
  // CPU side. The call is taken only at an ordinary instruction end; the
  // return itself is no boundary, so one instruction always follows it.
  assign irq_take_o = irq_req_o & instr_done_i & ~reti_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_req_o <= 1'b0;
    else
      irq_req_o <= next_req & ~irq_take_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_q <= '0;
      lvl_q <= '0;
      irq_vec_o <= VEC_RESET;
    end
    else if (next_req)
    begin
      src_q <= win.src;
      lvl_q <= win.lvl;
      irq_vec_o <= next_vec;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      in_srv <= '0;
    else if (irq_take_o)
      in_srv[lvl_q] <= 1'b1;
    else if (reti_i && busy)
      in_srv[top] <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gate_q <= '0;
    else
      gate_q <= req_vec;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_event_sets:
  assert property (|evt_v |=> (pend & $past(evt_v)) == $past(evt_v))
  else $error("event did not set its pending flag");

  chk_global_gate:
  assert property (!global_en |=> !irq_req_o)
  else $error("request raised with global enable low");

  chk_mask_gate:
  assert property (irq_req_o |-> gate_q[src_q])
  else $error("request from a masked or idle source");

  chk_preempt_level:
  assert property (irq_take_o && busy |-> lvl_q > top)
  else $error("preemption by equal or lower level");

  chk_service_push:
  assert property (irq_take_o |=> in_srv[$past(lvl_q)])
  else $error("taken level not marked in service");

  chk_reti_pop:
  assert property (reti_i && busy && !irq_take_o |=> !in_srv[$past(top)])
  else $error("return did not release top level");

  chk_hw_clear:
  assert property (irq_take_o && HW_CLR[src_q] && !evt_v[src_q]
                   && !sw_set[src_q] |=> !pend[$past(src_q)])
  else $error("auto-clear flag still set after vectoring");

  chk_detect_once:
  assert property (next_req && !irq_take_o |=> irq_req_o)
  else $error("request not raised one cycle after detection");

  chk_vector_map:
  assert property (irq_req_o |->
                   irq_vec_o == VEC_BASE + VEC_W'(src_q) * VEC_STEP)
  else $error("vector does not match source position");

  chk_reset_vector:
  assert property ($past(rst_i) |-> irq_vec_o == VEC_RESET && !irq_req_o)
  else $error("reset vector wrong after reset");

  chk_reserved_idle:
  assert property ((pend & ~SRC_VALID) == '0)
  else $error("reserved position pending");

  // The return itself is never a call boundary
  chk_reti_boundary:
  assert property (reti_i |-> !irq_take_o)
  else $error("call taken at the return boundary");

  chk_sw_set:
  assert property (|sw_set |=> (pend & $past(sw_set)) == $past(sw_set))
  else $error("software set did not reach the pending flag");

  // The winner of the cycle before must have passed its auxiliary gate
  chk_aux_gate:
  assert property (irq_req_o && HAS_AUX[src_q] |-> $past(aux_en[win.src]))
  else $error("request from a source with its auxiliary enable low");

  chk_top_locked:
  assert property (irq_take_o |-> !in_srv[NUM_LVL-1])
  else $error("call taken while the top level is in service");

  chk_reset_levels:
  assert property ($past(rst_i) |->
                   prio_lo == PRIO_RST && prio_hi == PRIO_RST)
  else $error("priority not lowest after reset");

  chk_global_reset:
  assert property ($past(rst_i) |-> primary == PRIMARY_RST)
  else $error("primary mask not cleared by reset");

  // Independent of the scan order above: no request may beat the winner
  for (genvar c = 0; c < NUM_SRC; c++)
  begin : g_chk
    chk_tie_order:
    assert property (@(posedge clk_i) disable iff (rst_i)
                     req_vec[c] |-> win.lvl > lvl[c]
                     || (win.lvl == lvl[c] && win.src <= c))
    else $error("arbitration picked the wrong source");
  end

  cov_take: cover property (irq_take_o);
  cov_nested: cover property (irq_take_o && busy);
  cov_reenter: cover property (reti_i ##[1:20] irq_take_o);
  cov_tie: cover property (win.valid && $countones(req_vec) > 1);
  cov_aux_take: cover property (irq_take_o && HAS_AUX[src_q]);

endmodule : pic_ctrl

// *** common/pic_pkg.sv ***
package pic_pkg;
  localparam int NUM_SRC = 22;
  localparam int SRC_W = 5;
  localparam int LVL_W = 2;
  localparam int NUM_LVL = 4;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int BYTE_W = 8;
  localparam int VEC_W = 16;
  localparam int PRI_W = 8;
  localparam int EXT_W = 15;
  localparam int GLB_BIT = 7;
  localparam logic [ADR_W-1:0] OFS_PRIO_LO = 8'h80;
  localparam logic [ADR_W-1:0] OFS_PRIO_HI = 8'h84;
  localparam logic [ADR_W-1:0] OFS_EXT_MASK = 8'h88;
  localparam logic [ADR_W-1:0] OFS_AUX_EN = 8'h8c;
  localparam logic [ADR_W-1:0] OFS_PEND = 8'h90;
  localparam logic [ADR_W-1:0] OFS_PEND_CLR = 8'h94;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h98;
  localparam logic [ADR_W-1:0] OFS_PRIMARY = 8'ha8;
  localparam logic [PRI_W-1:0] PRIMARY_RST = 8'h00;
  localparam logic [EXT_W-1:0] EXT_RST = 15'h0000;
  localparam logic [NUM_SRC-1:0] PRIO_RST = 22'h000000;
  localparam logic [NUM_SRC-1:0] AUX_RST = 22'h000000;
  // Positions 19 and 20 of the table are reserved
  localparam logic [NUM_SRC-1:0] SRC_VALID = 22'h27ffff;
  localparam logic [NUM_SRC-1:0] HAS_AUX = 22'h27f870;
  localparam logic [NUM_SRC-1:0] HW_CLR = 22'h00000f;
  localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;

  typedef struct packed {
    logic valid;
    logic [LVL_W-1:0] lvl;
    logic [SRC_W-1:0] src;
  } pic_win_t;

  typedef struct packed {
    logic [SRC_W-1:0] src;
    logic req;
    logic [NUM_LVL-1:0] in_srv;
  } pic_status_t;
endpackage : pic_pkg

// *** tb/pic_cpu_model.sv ***
`timescale 1ns/1ps
module pic_cpu_model
(
  input wire logic clk_i,
  input wire logic irq_take_i,
  output logic instr_done_o,
  output logic reti_o
);
  initial
  begin
    instr_done_o = 1'b0;
    reti_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-cycle instruction; the call can only start in its last cycle
  task automatic instr(output logic took);
    @(posedge clk_i);
    instr_done_o <= 1'b1;
    @(posedge clk_i);
    took = irq_take_i;
    instr_done_o <= 1'b0;
  endtask : instr

  // Return takes 5 cycles; completion is flagged only in the last one
  task automatic reti();
    repeat (4) @(posedge clk_i);
    reti_o <= 1'b1;
    @(posedge clk_i);
    reti_o <= 1'b0;
  endtask : reti
endmodule : pic_cpu_model

// *** tb/pic_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module pic_ctrl_tb_top
  import pic_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [NUM_SRC-1:0] ev = '0;
  logic [DAT_W-1:0] rdat;
  logic ack, req, take, done, ret;
  logic [VEC_W-1:0] vec;
  int n_fail = 0;
  int n_compared = 0;

  pic_ctrl pic_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .src_event_i(ev),
    .instr_done_i(done), .reti_i(ret), .irq_req_o(req), .irq_vec_o(vec),
    .irq_take_o(take));

  pic_cpu_model pic_cpu_model_i (.clk_i(clk_i), .irq_take_i(take),
    .instr_done_o(done), .reti_o(ret));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] e);
    n_compared++;
    if (got !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  // Classic cycle; reads see pre-edge values, i.e. what the slave drove
  task automatic wb(input logic [ADR_W-1:0] a, input logic w,
                    input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    if (k >= 50)
      n_fail++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
    logic [DAT_W-1:0] q;
    wb(a, 1'b0, '0, q);
    chk(q, e);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic t;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_PRIMARY, 32'h0);
    rd(OFS_PRIO_HI, 32'h0);
    rd(8'hfc, 32'h0);
    @(posedge clk_i);
    ev <= 22'h000002;
    @(posedge clk_i);
    ev <= '0;
    tick(3);
    chk({31'h0, req}, 32'h0);
    rd(OFS_PEND, 32'h2);
    wr(OFS_PRIMARY, 32'h02);
    tick(3);
    chk({31'h0, req}, 32'h0);
    wr(OFS_PRIMARY, 32'h82);
    tick(3);
    chk({31'h0, req}, 32'h1);
    chk({16'h0, vec}, 32'h000b);
    pic_cpu_model_i.instr(t);
    chk({31'h0, t}, 32'h1);
    rd(OFS_PEND, 32'h0);
    pic_cpu_model_i.reti();
    // Source 7 at level 3 against source 2 at level 0
    wr(OFS_PRIO_LO, 32'h80);
    wr(OFS_PRIO_HI, 32'h80);
    wr(OFS_EXT_MASK, 32'h1);
    wr(OFS_PRIMARY, 32'h84);
    rd(OFS_PRIO_HI, 32'h80);
    @(posedge clk_i);
    ev <= 22'h000084;
    @(posedge clk_i);
    ev <= '0;
    @(posedge clk_i);
    chk({31'h0, req}, 32'h0);
    @(posedge clk_i);
    chk({31'h0, req}, 32'h1);
    chk({16'h0, vec}, 32'h003b);
    pic_cpu_model_i.instr(t);
    chk({31'h0, t}, 32'h1);
    tick(3);
    chk({31'h0, req}, 32'h0);
    pic_cpu_model_i.reti();
    tick(2);
    chk({31'h0, req}, 32'h1);
    chk({16'h0, vec}, 32'h003b);
    pic_cpu_model_i.instr(t);
    chk({31'h0, t}, 32'h1);
    wr(OFS_PEND_CLR, 32'h80);
    pic_cpu_model_i.reti();
    tick(2);
    chk({16'h0, vec}, 32'h0013);
    pic_cpu_model_i.instr(t);
    chk({31'h0, t}, 32'h1);
    // Software raises source 7 while source 2 is in service at level 0
    wr(OFS_PEND, 32'h80);
    tick(2);
    chk({31'h0, req}, 32'h1);
    chk({16'h0, vec}, 32'h003b);
    rd(OFS_STATUS, 32'h0f1);
    pic_cpu_model_i.instr(t);
    chk({31'h0, t}, 32'h1);
    wr(OFS_PEND_CLR, 32'h80);
    pic_cpu_model_i.reti();
    rd(OFS_STATUS, 32'h0e1);
    pic_cpu_model_i.reti();
    // Two auxiliary sources at level 0; reserved positions never latch
    wr(OFS_PRIMARY, 32'hb0);
    rd(OFS_PRIO_HI, 32'h80);
    @(posedge clk_i);
    ev <= 22'h180030;
    @(posedge clk_i);
    ev <= '0;
    tick(3);
    chk({31'h0, req}, 32'h0);
    rd(OFS_PEND, 32'h30);
    wr(OFS_AUX_EN, 32'h20);
    tick(2);
    chk({31'h0, req}, 32'h1);
    chk({16'h0, vec}, 32'h002b);
    wr(OFS_AUX_EN, 32'h30);
    tick(2);
    chk({16'h0, vec}, 32'h0023);
    pic_cpu_model_i.instr(t);
    chk({31'h0, t}, 32'h1);
    tick(3);
    chk({31'h0, req}, 32'h0);
    wr(OFS_PEND_CLR, 32'h10);
    pic_cpu_model_i.reti();
    tick(2);
    chk({31'h0, req}, 32'h1);
    chk({16'h0, vec}, 32'h002b);
    pic_cpu_model_i.instr(t);
    chk({31'h0, t}, 32'h1);
    wr(OFS_PEND_CLR, 32'h20);
    pic_cpu_model_i.reti();
    rd(OFS_PEND, 32'h0);
    test_done();
  end

  // Whole run is under two hundred cycles
  initial
  begin
    repeat (4000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
endmodule : pic_ctrl_tb_top
